// File: logic/cig_glue.sv
// Purpose: processor core integration and debug glue
// Assumes: core signals on core_clk, debug probe clock on swclk
// Notes: register port is a plain strobe port, read data one cycle later
//
// Contract
// - sixty-four interrupt inputs; line count field reads 0x01
// - priority bytes keep three significant bits only
// - core reset request performs the full device system reset
// - core_stuck_indication output unused; leaving core_stuck_indication needs non-maskable irq or reset
// - auxiliary fault status always reads zero
// - no exclusive access monitor on the data code bus
// - trace leaves on four data lines with one trace clock
// - trace line zero may carry the single line viewer stream
// - two debug pins: clock pulled down, data two-way pulled up
// - port F trace pins reset as plain port bits, all controls zero
// - watchdog stops during debug halt; other peripherals keep running
// - two literal, six instruction, four watch comparators; no protection, wake
`timescale 1ns/1ps
module cig_glue (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic swclk,
  input wire logic [cig_pkg::ADDR_W-1:0] regAddr,
  input wire logic [cig_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [cig_pkg::DATA_W-1:0] regRdData,
  input wire logic coreResetRequest,
  input wire logic coreHalted,
  input wire logic [3:0] traceNibble,
  input wire logic traceValid,
  output logic traceReady,
  output logic sysResetOut,
  output logic wdogRun,
  output logic eventToCore,
  output logic exclusiveOkay,
  input wire logic swdioIn,
  output logic swdioOut,
  output logic swdioOe,
  output logic swdioPullUp,
  output logic swclkPullDown,
  input wire logic [cig_pkg::PF_W-1:0] portFIn,
  output logic [cig_pkg::PF_W-1:0] portFOut,
  output logic [cig_pkg::PF_W-1:0] portFOe,
  output logic [cig_pkg::PF_W-1:0] portFPullUp,
  output logic [cig_pkg::PF_W-1:0] portFInEn,
  output logic [cig_pkg::PF_W-1:0] portFPullDown
);
  import cig_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [PF_W-1:0] pfFunc;
  logic [PF_W-1:0] pfOe;
  logic [PF_W-1:0] pfPup;
  logic [PF_W-1:0] pfIe;
  logic [PF_W-1:0] pfData;
  logic viewerMode;
  logic [7:0] prioByte;
  logic resetCause;
  logic [7:0] lineResetCnt;
  logic linkActiveCore;
  logic [PF_W-1:0] pfInS1;
  logic [PF_W-1:0] pfInS2;
  logic [PF_W-1:0] pfInS3;
  logic [PF_W-1:0] pfInLevel;
  logic traceClkOut;
  logic [3:0] traceDataOut;

  // address decode
  wire wrFunc = regWr && (regAddr == OFS_PFFUNC);
  wire wrOe = regWr && (regAddr == OFS_PFOE);
  wire wrPup = regWr && (regAddr == OFS_PFPUP);
  wire wrIe = regWr && (regAddr == OFS_PFIE);
  wire wrData = regWr && (regAddr == OFS_PFDATA);
  wire wrTrc = regWr && (regAddr == OFS_TRCCTRL);
  wire wrPrio = regWr && (regAddr == OFS_PRIO);
  wire wrStat = regWr && (regAddr == OFS_DBGSTAT);

  ////////////////////////////////////////////////////////////////////////
  // fixed configuration words and the live debug status word
  wire [DATA_W-1:0] intCfgWord = DATA_W'(
    (32'(IRQ_LINE_COUNT_FIELD) << IRQ_COUNT_LSB) |
    (32'(PRIO_BITS) << PRIO_BITS_LSB));
  wire [DATA_W-1:0] optionsWord = DATA_W'(
    (32'(BKPT_LITERAL_CMP) << OPT_LIT_LSB) |
    (32'(BKPT_INSTR_CMP) << OPT_INS_LSB) |
    (32'(WATCH_CMP) << OPT_WCH_LSB) |
    (32'h1 << OPT_TRC_BIT));
  wire [DATA_W-1:0] statusWord = DATA_W'(
    (32'(resetCause) << DS_CAUSE_BIT) | (32'(linkActiveCore) << DS_LINK_BIT)
    | (32'(coreHalted) << DS_HALT_BIT)
    | (32'(lineResetCnt) << DS_LRCNT_LSB));

  // widen a port F field to a bus word
  function automatic logic [DATA_W-1:0] pfWord(input logic [PF_W-1:0] v);
    pfWord = {{(DATA_W - PF_W){1'b0}}, v};
  endfunction

  // read selection; auxiliary fault and unmapped offsets give zero
  wire [DATA_W-1:0] rdMux =
    (regAddr == OFS_INTCFG) ? intCfgWord :
    (regAddr == OFS_AUXFAULT) ? 32'h0000_0000 :
    (regAddr == OFS_OPTIONS) ? optionsWord :
    (regAddr == OFS_PFFUNC) ? pfWord(pfFunc) :
    (regAddr == OFS_PFOE) ? pfWord(pfOe) :
    (regAddr == OFS_PFPUP) ? pfWord(pfPup) :
    (regAddr == OFS_PFIE) ? pfWord(pfIe) :
    (regAddr == OFS_PFDATA) ? pfWord(pfInLevel) :
    (regAddr == OFS_DBGSTAT) ? statusWord :
    (regAddr == OFS_TRCCTRL) ? {31'h0, viewerMode} :
    (regAddr == OFS_PRIO) ? {24'h0, prioByte} : 32'h0000_0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port F controls, all cleared at reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pfFunc <= PF_RESET;
      pfOe <= PF_RESET;
      pfPup <= PF_RESET;
      pfIe <= PF_RESET;
      pfData <= PF_RESET;
    end else begin
      if (wrFunc) pfFunc <= regWrData[PF_W-1:0];
      if (wrOe) pfOe <= regWrData[PF_W-1:0];
      if (wrPup) pfPup <= regWrData[PF_W-1:0];
      if (wrIe) pfIe <= regWrData[PF_W-1:0];
      if (wrData) pfData <= regWrData[PF_W-1:0];
    end
  end

  // trace mode and priority byte; low priority bits are not stored
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      viewerMode <= 1'b0;
      prioByte <= PRIO_RESET;
    end else begin
      if (wrTrc) viewerMode <= regWrData[TC_VIEWER_BIT];
      if (wrPrio) prioByte <= {regWrData[7:PRIO_KEEP_LSB], 5'h00};
    end
  end

  // port F input pins pass three stages; a change needs stages 2 and 3
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pfInS1 <= 5'h00;
      pfInS2 <= 5'h00;
      pfInS3 <= 5'h00;
      pfInLevel <= 5'h00;
    end else begin
      pfInS1 <= portFIn;
      pfInS2 <= pfInS1;
      pfInS3 <= pfInS2;
      pfInLevel <= (pfInS2 & pfInS3 & pfIe) | (pfInLevel & (pfInS2 | pfInS3)
        & pfIe);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trace port unit
  cig_trace_port uTrace (
    .core_clk(core_clk),
    .rst(rst),
    .viewerMode(viewerMode),
    .traceNibble(traceNibble),
    .traceValid(traceValid),
    .traceReady(traceReady),
    .traceClkOut(traceClkOut),
    .traceDataOut(traceDataOut)
  );

  // pin sharing: function bit picks trace over plain port data
  wire [PF_W-1:0] traceLines = {traceDataOut, traceClkOut};
  wire [PF_W-1:0] next_portFOut = (pfFunc & traceLines) | (~pfFunc & pfData);
  wire [PF_W-1:0] next_portFOe = pfFunc | pfOe;

  // pin drivers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      portFOut <= 5'h00;
      portFOe <= 5'h00;
      portFPullUp <= 5'h00;
      portFInEn <= 5'h00;
      portFPullDown <= 5'h00;
    end else begin
      portFOut <= next_portFOut;
      portFOe <= next_portFOe;
      portFPullUp <= pfPup;
      portFInEn <= pfIe;
      portFPullDown <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset request: three stages, then a held system reset pulse
  logic reqS1;
  logic reqS2;
  logic reqS3;
  logic reqLevel;
  logic [7:0] holdCnt;
  wire reqEdge = reqS2 && reqS3 && !reqLevel;
  // core_stuck_indication is not a reset source, only the request is
  wire resetStart = reqEdge;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
      reqLevel <= 1'b0;
    end else begin
      reqS1 <= coreResetRequest;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
      if (reqS2 == reqS3) reqLevel <= reqS3;
    end
  end

  // hold counter drives the reset generator; cause stays for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      holdCnt <= 8'h00;
      sysResetOut <= 1'b0;
      resetCause <= 1'b0;
    end else begin
      if (resetStart) holdCnt <= 8'(RST_HOLD_CYCLES - 1);
      else if (holdCnt != 8'h00) holdCnt <= holdCnt - 8'h01;
      sysResetOut <= resetStart || (holdCnt != 8'h00);
      if (resetStart) resetCause <= 1'b1; // set wins over clear
      else if (wrStat && regWrData[DS_CAUSE_BIT]) resetCause <= 1'b0;
    end
  end

  // watchdog gate and fixed core side answers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdogRun <= 1'b0;
      eventToCore <= 1'b0;
      exclusiveOkay <= 1'b0;
    end else begin
      wdogRun <= !coreHalted;
      eventToCore <= 1'b0;
      exclusiveOkay <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: line reset watch on the probe clock
  logic [5:0] highCnt;
  logic lineResetTgl;
  logic linkActive;
  logic armed;
  wire hitReset = swdioIn && (highCnt == 6'(LINE_RESET_BITS - 1));

  always_ff @(posedge swclk or posedge rst) begin
    if (rst) begin
      highCnt <= 6'h00;
      lineResetTgl <= 1'b0;
      armed <= 1'b0;
      linkActive <= 1'b0;
    end else begin
      if (!swdioIn) highCnt <= 6'h00;
      else if (highCnt != 6'(LINE_RESET_BITS)) highCnt <= highCnt + 6'h01;
      if (hitReset) lineResetTgl <= !lineResetTgl;
      if (hitReset) armed <= 1'b1;
      else if (armed && !swdioIn) linkActive <= 1'b1;
    end
  end

  // data line pulls fixed on, driver released in this build
  always_ff @(posedge swclk or posedge rst) begin
    if (rst) begin
      swdioOut <= 1'b0;
      swdioOe <= 1'b0;
      swdioPullUp <= 1'b1;
      swclkPullDown <= 1'b1;
    end else begin
      swdioOut <= 1'b0;
      swdioOe <= 1'b0;
      swdioPullUp <= 1'b1;
      swclkPullDown <= 1'b1;
    end
  end

  // crossing into the core domain: level and toggle, three stages each
  logic [2:0] actSync;
  logic [2:0] tglSync;
  logic tglLevel;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      actSync <= 3'h0;
      tglSync <= 3'h0;
      linkActiveCore <= 1'b0;
      tglLevel <= 1'b0;
      lineResetCnt <= 8'h00;
    end else begin
      actSync <= {actSync[1:0], linkActive};
      tglSync <= {tglSync[1:0], lineResetTgl};
      if (actSync[1] == actSync[2]) linkActiveCore <= actSync[2];
      if (tglSync[1] == tglSync[2]) tglLevel <= tglSync[2];
      if ((tglSync[1] == tglSync[2]) && (tglSync[2] != tglLevel))
        lineResetCnt <= lineResetCnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  lineCount_a: assert property (@(posedge core_clk) disable iff (rst)
    regRd && regAddr == OFS_INTCFG |=> regRdData[4:0] == 5'h01)
    else $error("line count field wrong");
  prioBits_a: assert property (@(posedge core_clk) disable iff (rst)
    wrPrio |=> prioByte == {$past(regWrData[7:5]), 5'h00})
    else $error("priority byte wrong");
  resetStart_a: assert property (@(posedge core_clk) disable iff (rst)
    reqEdge |=> sysResetOut && resetCause)
    else $error("reset request not acted on");
  resetHold_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(sysResetOut) |-> sysResetOut[*8] ##1 sysResetOut[*2] ##1
    !sysResetOut)
    else $error("system reset length wrong");
  syncDelay_a: assert property (@(posedge core_clk) disable iff (rst)
    reqEdge |-> $past(coreResetRequest, 3))
    else $error("request not synchronized");
  auxZero_a: assert property (@(posedge core_clk) disable iff (rst)
    regRd && regAddr == OFS_AUXFAULT |=> regRdData == 32'h0000_0000)
    else $error("aux fault not zero");
  exclNone_a: assert property (@(posedge core_clk) disable iff (rst)
    !exclusiveOkay && !eventToCore)
    else $error("fixed core answers active");
  wdogHalt_a: assert property (@(posedge core_clk) disable iff (rst)
    coreHalted |=> !wdogRun)
    else $error("watchdog ran in halt");
  pfReset_a: assert property (@(posedge core_clk)
    $fell(rst) |-> pfFunc == 5'h00 && pfOe == 5'h00 && pfPup == 5'h00)
    else $error("port F not cleared");
  swdPull_a: assert property (@(posedge swclk) disable iff (rst)
    swdioPullUp && swclkPullDown && !swdioOe)
    else $error("debug pin pulls wrong");
  options_a: assert property (@(posedge core_clk) disable iff (rst)
    regRd && regAddr == OFS_OPTIONS |=> regRdData == 32'h0000_4462)
    else $error("option word wrong");
  traceMux_a: assert property (@(posedge core_clk) disable iff (rst)
    pfFunc[0] |=> portFOut[0] == $past(traceClkOut))
    else $error("trace clock not on pin");
  resetCov_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(sysResetOut));
  haltCov_c: cover property (@(posedge core_clk) disable iff (rst)
    coreHalted ##1 !wdogRun);
  linkCov_c: cover property (@(posedge core_clk) disable iff (rst)
    $rose(linkActiveCore));
endmodule

// File: logic/cig_pkg.sv
// Purpose: shared constants of the core integration and debug glue
// Assumes: 100 MHz core clock, byte addressed register port
// Notes: register words are 32 bits, unmapped reads return zero
package cig_pkg;
  // register port shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PF_W = 5;
  // register byte offsets
  localparam logic [7:0] OFS_INTCFG = 8'h00;
  localparam logic [7:0] OFS_AUXFAULT = 8'h04;
  localparam logic [7:0] OFS_OPTIONS = 8'h08;
  localparam logic [7:0] OFS_PFFUNC = 8'h0C;
  localparam logic [7:0] OFS_PFOE = 8'h10;
  localparam logic [7:0] OFS_PFPUP = 8'h14;
  localparam logic [7:0] OFS_PFIE = 8'h18;
  localparam logic [7:0] OFS_PFDATA = 8'h1C;
  localparam logic [7:0] OFS_DBGSTAT = 8'h20;
  localparam logic [7:0] OFS_TRCCTRL = 8'h24;
  localparam logic [7:0] OFS_PRIO = 8'h28;
  // interrupt configuration fields
  localparam int IRQ_LINES = 64;
  localparam logic [4:0] IRQ_LINE_COUNT_FIELD = 5'h01;
  localparam int IRQ_COUNT_LSB = 0;
  localparam logic [2:0] PRIO_BITS = 3'h3;
  localparam int PRIO_BITS_LSB = 8;
  localparam int PRIO_KEEP_LSB = 5;
  // debug option fields
  localparam logic [3:0] BKPT_LITERAL_CMP = 4'h2;
  localparam logic [3:0] BKPT_INSTR_CMP = 4'h6;
  localparam logic [3:0] WATCH_CMP = 4'h4;
  localparam int OPT_LIT_LSB = 0;
  localparam int OPT_INS_LSB = 4;
  localparam int OPT_WCH_LSB = 8;
  localparam int OPT_PROT_BIT = 12;
  localparam int OPT_WAKE_BIT = 13;
  localparam int OPT_TRC_BIT = 14;
  // debug status bits
  localparam int DS_CAUSE_BIT = 0;
  localparam int DS_LINK_BIT = 1;
  localparam int DS_HALT_BIT = 2;
  localparam int DS_LRCNT_LSB = 8;
  // trace control bits
  localparam int TC_VIEWER_BIT = 0;
  // reset values
  localparam logic [4:0] PF_RESET = 5'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_HOLD_NS = 100;
  localparam int RST_HOLD_CYCLES =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINE_RESET_BITS = 50;
endpackage

// File: logic/cig_trace_port.sv
// Purpose: trace port unit, four data lines plus clock or one line
// Assumes: trace words arrive on the core clock with valid and ready
// Notes: parallel mode takes one nibble every second cycle
`timescale 1ns/1ps
module cig_trace_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic viewerMode,
  input wire logic [3:0] traceNibble,
  input wire logic traceValid,
  output logic traceReady,
  output logic traceClkOut,
  output logic [3:0] traceDataOut
);
  logic phase;
  logic [5:0] shiftReg;
  logic [2:0] bitCnt;
  wire viewerIdle = (bitCnt == 3'h0);
  wire takeParallel = !viewerMode && !phase && traceValid;
  wire takeViewer = viewerMode && viewerIdle && traceValid;
  // ready when the selected path can accept a nibble
  assign traceReady = viewerMode ? viewerIdle : !phase;

  // parallel path: clock toggles every cycle, data changes with it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase <= 1'b0;
      traceClkOut <= 1'b0;
    end else begin
      phase <= viewerMode ? 1'b0 : !phase;
      traceClkOut <= viewerMode ? 1'b0 : !phase;
    end
  end

  // one line path: start bit, four data bits, stop bit, idle high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shiftReg <= 6'h3F;
      bitCnt <= 3'h0;
    end else if (takeViewer) begin
      shiftReg <= {1'b1, traceNibble, 1'b0};
      bitCnt <= 3'h6;
    end else if (!viewerIdle) begin
      shiftReg <= {1'b1, shiftReg[5:1]};
      bitCnt <= bitCnt - 3'h1;
    end
  end

  // output lines; line 0 carries the serial stream in one line mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      traceDataOut <= 4'h0;
    end else if (viewerMode) begin
      traceDataOut <= {3'h0, viewerIdle ? 1'b1 : shiftReg[0]};
    end else if (takeParallel) begin
      traceDataOut <= traceNibble;
    end
  end

  traceClock_a: assert property (@(posedge core_clk) disable iff (rst)
    !viewerMode && $past(!viewerMode) |=> traceClkOut != $past(traceClkOut))
    else $error("trace clock did not toggle");
  viewerLine_a: assert property (@(posedge core_clk) disable iff (rst)
    takeViewer |=> ##1 traceDataOut == 4'h0 ##1 traceDataOut[0] ==
    $past(traceNibble[0], 3))
    else $error("one line frame wrong");
  viewerCov_c: cover property (@(posedge core_clk) disable iff (rst)
    takeViewer);
endmodule

// File: tb/cig_probe_model.sv
// Purpose: debug probe and trace capture model for the glue bench
// Assumes: link clock half period 40 ns, core clock 10 ns
// Notes: link clock rests low and data line high outside frames
`timescale 1ns/1ps
module cig_probe_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic viewerPin,
  output logic swclk,
  output logic swdioDrv
);
  localparam time LINK_HALF = 40;
  //////////////////////////////////////////////////////////////////////////
  // idle levels, plus one link edge during reset so link flops settle
  initial begin
    swclk = 1'b0;
    swdioDrv = 1'b1;
    #20 swclk = 1'b1;
    #40 swclk = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // send n equal bits; data changes while the link clock is low
  task automatic send_bits(input int n, input logic val);
    while (rst !== 1'b0) #LINK_HALF;
    #13;
    repeat (n) begin
      swdioDrv = val;
      #LINK_HALF swclk = 1'b1;
      #LINK_HALF swclk = 1'b0;
    end
    swdioDrv = 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // capture one frame of the single line viewer: start, 4 bits, stop
  task automatic catch_viewer(output logic [3:0] nib, output logic ok);
    int i;
    ok = 1'b0;
    nib = 4'h0;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge core_clk);
      #1;
      if (viewerPin === 1'b0) ok = 1'b1;
    end
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      #1;
      nib[i] = viewerPin;
    end
    @(posedge core_clk);
    #1;
    if (viewerPin !== 1'b1) ok = 1'b0;
  endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for the core integration glue
// Assumes: register strobes driven by non-blocking assignment
// Notes: probe model supplies link clock and trace capture
`timescale 1ns/1ps
module testbench;
  import cig_pkg::*;
  logic core_clk, rst, swclk, swdioIn, swdioDrv, regWr, regRd, ok, t0;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, rdv;
  logic coreResetRequest, coreHalted, traceValid, traceReady;
  logic [3:0] traceNibble, nib;
  logic sysResetOut, wdogRun, eventToCore, exclusiveOkay;
  logic swdioOut, swdioOe, swdioPullUp, swclkPullDown;
  logic [PF_W-1:0] portFIn, portFOut, portFOe, portFPullUp, portFInEn;
  logic [PF_W-1:0] portFPullDown;
  logic [7:0] addrs [8];
  logic [31:0] exps [8];
  logic [3:0] nibs [2];
  int err_total, checks, n, h;
  //////////////////////////////////////////////////////////////////////////
  // wire level of the two-way data pin
  assign swdioIn = swdioOe ? swdioOut : swdioDrv;
  cig_glue dut (.core_clk, .rst, .swclk, .regAddr, .regWrData, .regWr,
    .regRd, .regRdData, .coreResetRequest, .coreHalted, .traceNibble,
    .traceValid, .traceReady, .sysResetOut, .wdogRun, .eventToCore,
    .exclusiveOkay, .swdioIn, .swdioOut, .swdioOe, .swdioPullUp,
    .swclkPullDown, .portFIn, .portFOut, .portFOe, .portFPullUp,
    .portFInEn, .portFPullDown);
  cig_probe_model probe (.core_clk, .rst, .viewerPin(portFOut[1]),
    .swclk, .swdioDrv);
  //////////////////////////////////////////////////////////////////////////
  // core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // report and compare tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, input string w);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, exp, input string w);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic fail(input string w);
    err_total++;
    $display("[ERR] %0t %s", $time, w);
    end_sim();
  endtask
  //////////////////////////////////////////////////////////////////////////
  // register port and trace handshake
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input string w);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk_word(regRdData, e, w);
  endtask
  task automatic send_trace(input logic [3:0] v);
    int i;
    @(posedge core_clk);
    traceNibble <= v;
    traceValid <= 1'b1;
    #1;
    for (i = 0; i < 20 && traceReady !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (traceReady !== 1'b1) fail("trace never ready");
    @(posedge core_clk);
    traceValid <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    {regWr, regRd, coreResetRequest, coreHalted, traceValid} = 5'h00;
    regAddr = 8'h00;
    regWrData = 32'h0;
    traceNibble = 4'h0;
    portFIn = 5'h00;
    err_total = 0;
    checks = 0;
    addrs = '{OFS_INTCFG, OFS_AUXFAULT, OFS_OPTIONS, OFS_PFFUNC,
      OFS_PFOE, OFS_PFPUP, OFS_PFIE, 8'h40};
    exps = '{32'h301, 32'h0, 32'h4462, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    nibs = '{4'h5, 4'hC};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk_word({17'h0, portFOut, portFOe, portFPullUp}, 32'h0, "pf");
    chk_word({22'h0, portFInEn, portFPullDown}, 32'h0, "pf enables");
    chk_pin({swdioPullUp, swclkPullDown, swdioOe, swdioOut, 4'h0},
      8'hC0, "pulls");
    chk_pin({6'h0, exclusiveOkay, eventToCore}, 8'h00, "unused");
    chk_pin({7'h0, wdogRun}, 8'h01, "watchdog runs");
    reg_wr(OFS_INTCFG, 32'hFFFFFFFF);
    reg_wr(OFS_AUXFAULT, 32'hFFFFFFFF);
    reg_wr(8'h40, 32'hFFFFFFFF);
    for (n = 0; n < 8; n++) begin
      rd_chk(addrs[n], exps[n], "map");
    end
    reg_wr(OFS_PRIO, 32'hFF);
    rd_chk(OFS_PRIO, 32'hE0, "priority bits");
    $display("test map done");
    reg_wr(OFS_PFOE, 32'h1F);
    reg_wr(OFS_PFDATA, 32'h15);
    reg_wr(OFS_PFPUP, 32'h03);
    reg_wr(OFS_PFIE, 32'h1F);
    portFIn <= 5'h0A;
    repeat (4) @(posedge core_clk);
    #1;
    chk_pin({3'h0, portFOut}, 8'h15, "port data");
    chk_pin({3'h0, portFPullUp}, 8'h03, "port pull-up");
    chk_pin({3'h0, portFInEn}, 8'h1F, "port input enable");
    rd_chk(OFS_PFDATA, 32'h0A, "pin levels");
    $display("test port done");
    @(posedge core_clk);
    coreResetRequest <= 1'b1;
    for (n = 1; n < 20; n++) begin
      @(posedge core_clk);
      #1;
      if (sysResetOut === 1'b1) break;
    end
    for (h = 0; h < 20 && sysResetOut === 1'b1; h++) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    coreResetRequest <= 1'b0;
    chk_pin(n[7:0], 8'h04, "reset delay");
    chk_pin(h[7:0], 8'h0A, "reset length");
    rd_chk(OFS_DBGSTAT, 32'h1, "reset cause");
    reg_wr(OFS_DBGSTAT, 32'h1);
    rd_chk(OFS_DBGSTAT, 32'h0, "cause cleared");
    $display("test reset request done");
    @(posedge core_clk);
    coreHalted <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin({7'h0, wdogRun}, 8'h00, "watchdog halted");
    rd_chk(OFS_DBGSTAT, 32'h4, "halt status");
    @(posedge core_clk);
    coreHalted <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_pin({7'h0, wdogRun}, 8'h01, "watchdog resumed");
    $display("test halt done");
    probe.send_bits(50, 1'b1);
    probe.send_bits(2, 1'b0);
    repeat (10) @(posedge core_clk);
    rd_chk(OFS_DBGSTAT, 32'h102, "line reset");
    $display("test link done");
    reg_wr(OFS_PFFUNC, 32'h1F);
    repeat (2) @(posedge core_clk);
    #1;
    t0 = portFOut[0];
    @(posedge core_clk);
    #1;
    chk_pin({7'h0, portFOut[0] ^ t0}, 8'h01, "trace clock");
    chk_pin({3'h0, portFOe}, 8'h1F, "trace pins driven");
    for (n = 0; n < 2; n++) begin
      send_trace(nibs[n]);
      repeat (2) @(posedge core_clk);
      #1;
      chk_pin({4'h0, portFOut[4:1]}, {4'h0, nibs[n]}, "nibble");
    end
    reg_wr(OFS_TRCCTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    #1;
    chk_pin({7'h0, portFOut[1]}, 8'h01, "viewer idle");
    send_trace(4'hA);
    probe.catch_viewer(nib, ok);
    chk_pin({3'h0, ok, nib}, 8'h1A, "viewer frame");
    $display("test trace done");
    end_sim();
  end
endmodule
